// [design/cfs_pkg.sv]
package cfs_pkg;

  // ***********************************************************
  // line-table entry layout
  // ***********************************************************
  localparam int LE_W         = 20;
  localparam int CNT_W        = 13;
  localparam int LE_CNT_LSB   = 0;
  localparam int LE_HCLK_BIT  = 13;
  localparam int LE_THIRD_BIT = 14;
  localparam int LE_AUX_BIT   = 15;
  localparam int LE_PHB_BIT   = 16;
  localparam int LE_PHA_BIT   = 17;
  localparam int LE_EXP_BIT   = 18;
  localparam int LE_DRAIN_BIT = 19;

  // ***********************************************************
  // frame-table entry layout
  // ***********************************************************
  localparam int FE_W         = 34;
  localparam int FE_INC_BIT   = 0;
  localparam int FE_CLR_BIT   = 1;
  localparam int FE_SHUT_BIT  = 2;
  localparam int FE_BIN_LSB   = 3;
  localparam int FE_BIN_W     = 2;
  localparam int FE_EN_LSB    = 5;
  localparam int FE_EN_W      = 11;
  localparam int FE_FLAG_BIT  = 16;
  localparam int FE_CNT_LSB   = 17;
  localparam int FE_ADDR_LSB  = 30;
  localparam int FE_ADDR_W    = 4;

  // ***********************************************************
  // serial write port
  // ***********************************************************
  localparam int SER_HDR_W     = 8;
  localparam int SER_RW_BIT    = 3;
  localparam int SER_AD_LSB    = 4;
  localparam int SER_AD_W      = 4;
  localparam int SER_DATA_W    = 40;
  localparam int SER_BCNT_W    = 7;
  localparam logic [2:0] SER_DEV_SEQ = 3'h3;
  localparam logic [3:0] REG_FT_PTR  = 4'h0;
  localparam logic [3:0] REG_FT      = 4'h8;
  localparam logic [3:0] REG_LT      = 4'h9;
  localparam int WLT_SEL_LSB   = 20;
  localparam int WLT_IDX_LSB   = 24;
  localparam int WLT_LAST_BIT  = 28;
  localparam int WFT_SEL_LSB   = 34;
  localparam int WFT_IDX_LSB   = 38;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_RUN   = 2'b10
  } cfs_state_type;

  // ***********************************************************
  // default tables
  // ***********************************************************
  function automatic logic [LE_W-1:0] le(input int cnt, input int h,
      input int pa, input int pb, input int th, input int ex);
    logic [LE_W-1:0] r;
    r = '0;
    r[LE_CNT_LSB +: CNT_W] = cnt[CNT_W-1:0];
    r[LE_HCLK_BIT]  = h[0];
    r[LE_PHA_BIT]   = pa[0];
    r[LE_PHB_BIT]   = pb[0];
    r[LE_THIRD_BIT] = th[0];
    r[LE_EXP_BIT]   = ex[0];
    return r;
  endfunction

  function automatic logic [LE_W-1:0] lt_default(input int t, input int e);
    logic [LE_W-1:0] r;
    r = '0;
    case (t)
      0: if (e == 0) r = le(1, 0, 0, 0, 0, 1);
      1: case (e)
           0: r = le(1,   0, 0, 0, 0, 0);
           1: r = le(800, 0, 0, 1, 0, 0);
           2: r = le(1,   0, 0, 1, 1, 0);
           3: r = le(358, 0, 1, 1, 1, 0);
           4: r = le(1,   0, 0, 1, 1, 0);
           5: r = le(300, 0, 0, 1, 0, 0);
           6: r = le(800, 0, 0, 0, 0, 0);
           default: r = '0;
         endcase
      2: case (e)
           0: r = le(1,  0, 0, 0, 0, 0);
           1: r = le(1,  0, 0, 1, 0, 0);
           2: r = le(38, 0, 1, 1, 0, 0);
           3: r = le(1,  0, 0, 1, 0, 0);
           4: r = le(30, 1, 0, 0, 0, 0);
           default: r = '0;
         endcase
      3: case (e)
           0: r = le(1,  0, 0, 0, 0, 0);
           1: r = le(1,  0, 0, 1, 0, 0);
           2: r = le(38, 0, 1, 1, 0, 0);
           3: r = le(1,  0, 0, 1, 0, 0);
           4: r = le(40, 0, 0, 0, 0, 0);
           5: r = le(1,  0, 0, 1, 0, 0);
           6: r = le(38, 0, 1, 1, 0, 0);
           7: r = le(1,  0, 0, 1, 0, 0);
           8: r = le(30, 1, 0, 0, 0, 0);
           default: r = '0;
         endcase
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic int lt_last_default(input int t);
    case (t)
      1:       return 6;
      2:       return 4;
      3:       return 8;
      default: return 0;
    endcase
  endfunction

  function automatic logic [FE_W-1:0] fe(input logic [15:0] low,
      input int flag, input int cnt, input int addr);
    logic [FE_W-1:0] r;
    r = '0;
    r[15:0] = low;
    r[FE_FLAG_BIT] = flag[0];
    r[FE_CNT_LSB +: CNT_W] = cnt[CNT_W-1:0];
    r[FE_ADDR_LSB +: FE_ADDR_W] = addr[FE_ADDR_W-1:0];
    return r;
  endfunction

  function automatic logic [FE_W-1:0] ft_default(input int t, input int e);
    logic [FE_W-1:0] r;
    r = '0;
    case (e)
      0: r = fe(16'h8202, 1, 0, 0);
      1: r = fe(16'h8202, 0, 1, 1);
      2: r = (t == 0) ? fe(16'he2c1, 0, 1056, 2) : fe(16'he2c9, 0, 528, 3);
      3: r = (t == 0) ? fe(16'h0200, 0, 0, 0) : fe(16'h0000, 0, 0, 1);
      default: r = '0;
    endcase
    return r;
  endfunction

endpackage

// [design/cfs_line_engine.sv]
`timescale 1ns/1ns
module cfs_line_engine #(
  parameter int E_AW = 4
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        start_i,
  input  wire logic [cfs_pkg::LE_W-1:0]    entry_i,
  input  wire logic [E_AW-1:0]             last_idx_i,
  output logic      [E_AW-1:0]             idx_o,
  output logic                             done_o,
  output logic                             ph_a_o,
  output logic                             ph_b_o,
  output logic                             third_o,
  output logic                             aux_o,
  output logic                             exp_o,
  output logic                             drain_o,
  output logic                             hclk_o
);

  logic [cfs_pkg::CNT_W-1:0] cnt_q;
  logic [E_AW-1:0]           idx_q;
  logic                      busy_q;
  logic                      done_q;
  logic                      ent_end;
  logic                      tab_end;

  // count 0 behaves as one cycle
  assign ent_end = cnt_q >= entry_i[cfs_pkg::LE_CNT_LSB +: cfs_pkg::CNT_W];
  assign tab_end = ent_end && (idx_q == last_idx_i);
  assign idx_o   = idx_q;
  assign done_o  = done_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      idx_q  <= '0;
      cnt_q  <= '0;
    end else if (start_i) begin
      busy_q <= 1'b1;
      idx_q  <= '0;
      cnt_q  <= {{(cfs_pkg::CNT_W-1){1'b0}}, 1'b1};
    end else if (busy_q) begin
      if (tab_end) begin
        busy_q <= 1'b0;
      end else if (ent_end) begin
        idx_q <= idx_q + 1'b1;
        cnt_q <= {{(cfs_pkg::CNT_W-1){1'b0}}, 1'b1};
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && tab_end && !start_i;
    end
  end

  // levels held from flops for the whole entry
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_a_o  <= 1'b0;
      ph_b_o  <= 1'b0;
      third_o <= 1'b0;
      aux_o   <= 1'b0;
      exp_o   <= 1'b0;
      drain_o <= 1'b0;
      hclk_o  <= 1'b0;
    end else if (busy_q) begin
      ph_a_o  <= entry_i[cfs_pkg::LE_PHA_BIT];
      ph_b_o  <= entry_i[cfs_pkg::LE_PHB_BIT];
      third_o <= entry_i[cfs_pkg::LE_THIRD_BIT];
      aux_o   <= entry_i[cfs_pkg::LE_AUX_BIT];
      exp_o   <= entry_i[cfs_pkg::LE_EXP_BIT];
      drain_o <= entry_i[cfs_pkg::LE_DRAIN_BIT];
      hclk_o  <= entry_i[cfs_pkg::LE_HCLK_BIT];
    end
  end

endmodule

// [design/cfs_frame_seq.sv]
`timescale 1ns/1ns
// Behaviour
// - frame entry fields: counter ops, shutter, binning, enables, flag, count, address
// - normal frame: integrate, diode transfer on pulse, all lines, then back
// - one frame table active, pointer zero normal, one binned
// - binned frame: table 3, 528 lines, binning 1, jump to 1, same enables as normal
// - line entry: 13-bit count, hclk enable, six vertical levels held
// - four default line tables: integrate, diode, line, binned line
// - integration repeats until the controller's end-of-integration pulse
// - integration table: one entry, count 1, exposure high, rest low
// - diode transfer: seven entries, counts 1,800,1,358,1,300,800
// - diode transfer raises phase B third level, no horizontal clocks
// - phase overlap set by per-entry counts
// - line transfer: five entries 1,1,38,1,30, hclk last only
// - vertical interval first, horizontal readout after it
// - binned line: nine entries, two phase A pulses, hclk last
// - binned line pulses vertical clocks twice before readout
module cfs_frame_seq #(
  parameter int                NUM_LT       = 4,
  parameter int                LT_DEPTH     = 16,
  parameter int                NUM_FT       = 2,
  parameter int                FT_DEPTH     = 4,
  parameter logic [0:0]        FT_PTR_RESET = 1'b0
) (
  input  wire logic                         CLOCK_I,
  input  wire logic                         RST_N_I,
  input  wire logic                         SER_CLK_I,
  input  wire logic                         SER_DATA_I,
  input  wire logic                         SER_LOAD_N_I,
  input  wire logic                         FRAME_END_PULSE_I,
  output logic                              VERTICAL_PHASE_A_O,
  output logic                              VERTICAL_PHASE_B_O,
  output logic                              VERTICAL_THIRD_LEVEL_O,
  output logic                              VERTICAL_AUX_O,
  output logic                              EXPOSURE_LEVEL_O,
  output logic                              DRAIN_GATE_CTRL_O,
  output logic                              HCLK_GATE_O,
  output logic [cfs_pkg::FE_EN_W-1:0]       OUTPUT_ENABLES_O,
  output logic [cfs_pkg::FE_BIN_W-1:0]      HBIN_FACTOR_O,
  output logic                              FORCE_SHUTTER_START_O,
  output logic [cfs_pkg::CNT_W-1:0]         LINE_COUNT_O,
  output logic                              ACTIVE_FRAME_TABLE_O
);

  localparam int LT_AW = $clog2(NUM_LT);
  localparam int LE_AW = $clog2(LT_DEPTH);
  localparam int FT_AW = 1;
  localparam int FI_AW = $clog2(FT_DEPTH);

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [2:0] sclk_q;
  logic [2:0] sload_q;
  logic [1:0] sdata_q;
  logic [2:0] eoi_q;
  logic       sclk_rise;
  logic       load_end;
  logic       eoi_edge;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sclk_q  <= 3'h0;
      sload_q <= 3'h7;
      sdata_q <= 2'h0;
      eoi_q   <= 3'h0;
    end else begin
      sclk_q  <= {sclk_q[1:0], SER_CLK_I};
      sload_q <= {sload_q[1:0], SER_LOAD_N_I};
      sdata_q <= {sdata_q[0], SER_DATA_I};
      eoi_q   <= {eoi_q[1:0], FRAME_END_PULSE_I};
    end
  end

  assign sclk_rise = sclk_q[1] && !sclk_q[2];
  assign load_end  = sload_q[1] && !sload_q[2];
  assign eoi_edge  = eoi_q[1] && !eoi_q[2];

  // ***********************************************************
  // serial write receiver
  // ***********************************************************
  logic [cfs_pkg::SER_HDR_W-1:0]  hdr_q;
  logic [cfs_pkg::SER_DATA_W-1:0] wdata_q;
  logic [cfs_pkg::SER_BCNT_W-1:0] bcnt_q;
  logic [cfs_pkg::SER_BCNT_W-1:0] dpos;
  logic [2:0]                     dev_sel;
  logic [cfs_pkg::SER_AD_W-1:0]   waddr;
  logic                           wr_stb;

  assign dpos    = bcnt_q - cfs_pkg::SER_BCNT_W'(cfs_pkg::SER_HDR_W);
  assign dev_sel = {hdr_q[0], hdr_q[1], hdr_q[2]};
  assign waddr   = hdr_q[cfs_pkg::SER_AD_LSB +: cfs_pkg::SER_AD_W];
  assign wr_stb  = load_end && (dev_sel == cfs_pkg::SER_DEV_SEQ)
                   && !hdr_q[cfs_pkg::SER_RW_BIT]
                   && (bcnt_q > cfs_pkg::SER_BCNT_W'(cfs_pkg::SER_HDR_W));

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hdr_q   <= '0;
      wdata_q <= '0;
      bcnt_q  <= '0;
    end else if (sload_q[1]) begin
      bcnt_q <= '0;
    end else if (sclk_rise) begin
      if (bcnt_q < cfs_pkg::SER_BCNT_W'(cfs_pkg::SER_HDR_W)) begin
        hdr_q[bcnt_q[2:0]] <= sdata_q[1];
        wdata_q            <= '0;
      end else if (dpos < cfs_pkg::SER_BCNT_W'(cfs_pkg::SER_DATA_W)) begin
        wdata_q[dpos[5:0]] <= sdata_q[1];
      end
      if (bcnt_q != '1) begin
        bcnt_q <= bcnt_q + 1'b1;
      end
    end
  end

  // ***********************************************************
  // table storage, defaults loaded at reset
  // ***********************************************************
  logic [cfs_pkg::LE_W-1:0] lt_mem  [NUM_LT][LT_DEPTH];
  logic [LE_AW-1:0]         lt_last [NUM_LT];
  logic [cfs_pkg::FE_W-1:0] ft_mem  [NUM_FT][FT_DEPTH];
  logic [LT_AW-1:0]         w_lt_sel;
  logic [LE_AW-1:0]         w_lt_idx;
  logic [FT_AW-1:0]         w_ft_sel;
  logic [FI_AW-1:0]         w_ft_idx;

  assign w_lt_sel = wdata_q[cfs_pkg::WLT_SEL_LSB +: LT_AW];
  assign w_lt_idx = wdata_q[cfs_pkg::WLT_IDX_LSB +: LE_AW];
  assign w_ft_sel = wdata_q[cfs_pkg::WFT_SEL_LSB +: FT_AW];
  assign w_ft_idx = wdata_q[cfs_pkg::WFT_IDX_LSB +: FI_AW];

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int t = 0; t < NUM_LT; t++) begin
        lt_last[t] <= LE_AW'(cfs_pkg::lt_last_default(t));
        for (int e = 0; e < LT_DEPTH; e++) begin
          lt_mem[t][e] <= cfs_pkg::lt_default(t, e);
        end
      end
      for (int t = 0; t < NUM_FT; t++) begin
        for (int e = 0; e < FT_DEPTH; e++) begin
          ft_mem[t][e] <= cfs_pkg::ft_default(t, e);
        end
      end
    end else if (wr_stb) begin
      if (waddr == cfs_pkg::REG_LT) begin
        lt_mem[w_lt_sel][w_lt_idx] <= wdata_q[cfs_pkg::LE_W-1:0];
        if (wdata_q[cfs_pkg::WLT_LAST_BIT]) begin
          lt_last[w_lt_sel] <= w_lt_idx;
        end
      end else if (waddr == cfs_pkg::REG_FT) begin
        ft_mem[w_ft_sel][w_ft_idx] <= wdata_q[cfs_pkg::FE_W-1:0];
      end
    end
  end

  // ***********************************************************
  // frame pointer
  // ***********************************************************
  logic [FT_AW-1:0] ptr_q;
  logic             ptr_new_q;
  logic             ptr_wr;
  logic             do_jump;

  assign ptr_wr = wr_stb && (waddr == cfs_pkg::REG_FT_PTR);

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ptr_q     <= FT_PTR_RESET;
      ptr_new_q <= 1'b0;
    end else if (ptr_wr) begin
      ptr_q     <= wdata_q[FT_AW-1:0];
      ptr_new_q <= 1'b1;
    end else if (do_jump) begin
      ptr_new_q <= 1'b0;
    end
  end

  // ***********************************************************
  // frame sequencer
  // ***********************************************************
  cfs_pkg::cfs_state_type   state_q;
  logic [FT_AW-1:0]         act_q;
  logic [FI_AW-1:0]         fidx_q;
  logic [cfs_pkg::FE_W-1:0] cur;
  logic [cfs_pkg::CNT_W-1:0] rep_q;
  logic [cfs_pkg::CNT_W-1:0] rep_tgt_q;
  logic                     wait_q;
  logic                     inc_q;
  logic [LT_AW-1:0]         lt_sel_q;
  logic                     eoi_pend_q;
  logic                     eng_done;
  logic [LE_AW-1:0]         eng_idx;
  logic                     is_jump;
  logic                     fetch_run;
  logic                     advance;
  logic                     eng_start;
  logic                     eoi_take;

  assign cur     = ft_mem[act_q][fidx_q];
  assign is_jump = !cur[cfs_pkg::FE_FLAG_BIT]
                   && (cur[cfs_pkg::FE_CNT_LSB +: cfs_pkg::CNT_W] == '0);
  assign do_jump   = (state_q == cfs_pkg::ST_FETCH) && is_jump;
  assign fetch_run = (state_q == cfs_pkg::ST_FETCH) && !is_jump;
  assign eoi_take  = wait_q && (eoi_pend_q || eoi_edge);
  assign advance   = (state_q == cfs_pkg::ST_RUN) && eng_done
                     && (wait_q ? eoi_take : (rep_q + 1'b1 >= rep_tgt_q));
  assign eng_start = fetch_run
                     || ((state_q == cfs_pkg::ST_RUN) && eng_done && !advance);

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q   <= cfs_pkg::ST_FETCH;
      act_q     <= FT_PTR_RESET;
      fidx_q    <= '0;
      rep_q     <= '0;
      rep_tgt_q <= '0;
      wait_q    <= 1'b0;
      inc_q     <= 1'b0;
      lt_sel_q  <= '0;
    end else begin
      unique case (state_q)
        cfs_pkg::ST_FETCH: begin
          if (is_jump) begin
            act_q  <= ptr_new_q ? ptr_q : cur[cfs_pkg::FE_ADDR_LSB +: FT_AW];
            fidx_q <= '0;
          end else begin
            lt_sel_q  <= cur[cfs_pkg::FE_ADDR_LSB +: LT_AW];
            rep_tgt_q <= cur[cfs_pkg::FE_CNT_LSB +: cfs_pkg::CNT_W];
            wait_q    <= cur[cfs_pkg::FE_FLAG_BIT];
            inc_q     <= cur[cfs_pkg::FE_INC_BIT];
            rep_q     <= '0;
            state_q   <= cfs_pkg::ST_RUN;
          end
        end
        cfs_pkg::ST_RUN: begin
          if (advance) begin
            fidx_q  <= fidx_q + 1'b1;
            state_q <= cfs_pkg::ST_FETCH;
          end else if (eng_done && !wait_q) begin
            rep_q <= rep_q + 1'b1;
          end
        end
        default: begin
          state_q <= cfs_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // end-of-integration latch, consumption wins over a new pulse in the same cycle
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      eoi_pend_q <= 1'b0;
    end else if (eoi_edge && !(advance && eoi_take)) begin
      eoi_pend_q <= 1'b1;
    end else if (advance || (state_q == cfs_pkg::ST_FETCH)) begin
      eoi_pend_q <= 1'b0;
    end
  end

  // ***********************************************************
  // line counter and frame-entry outputs
  // ***********************************************************
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LINE_COUNT_O <= '0;
    end else if (fetch_run && cur[cfs_pkg::FE_CLR_BIT]) begin
      LINE_COUNT_O <= '0;
    end else if ((state_q == cfs_pkg::ST_RUN) && eng_done && inc_q) begin
      LINE_COUNT_O <= LINE_COUNT_O + 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUTPUT_ENABLES_O      <= '0;
      HBIN_FACTOR_O         <= '0;
      FORCE_SHUTTER_START_O <= 1'b0;
    end else begin
      FORCE_SHUTTER_START_O <= fetch_run && cur[cfs_pkg::FE_SHUT_BIT];
      if (fetch_run) begin
        OUTPUT_ENABLES_O <= cur[cfs_pkg::FE_EN_LSB +: cfs_pkg::FE_EN_W];
        HBIN_FACTOR_O    <= cur[cfs_pkg::FE_BIN_LSB +: cfs_pkg::FE_BIN_W];
      end
    end
  end

  assign ACTIVE_FRAME_TABLE_O = act_q;

  // ***********************************************************
  // line-table engine
  // ***********************************************************
  cfs_line_engine #(
    .E_AW (LE_AW)
  ) u_engine (
    .clk_i      (CLOCK_I),
    .rst_n_i    (RST_N_I),
    .start_i    (eng_start),
    .entry_i    (lt_mem[lt_sel_q][eng_idx]),
    .last_idx_i (lt_last[lt_sel_q]),
    .idx_o      (eng_idx),
    .done_o     (eng_done),
    .ph_a_o     (VERTICAL_PHASE_A_O),
    .ph_b_o     (VERTICAL_PHASE_B_O),
    .third_o    (VERTICAL_THIRD_LEVEL_O),
    .aux_o      (VERTICAL_AUX_O),
    .exp_o      (EXPOSURE_LEVEL_O),
    .drain_o    (DRAIN_GATE_CTRL_O),
    .hclk_o     (HCLK_GATE_O)
  );

endmodule

// [verif/cfs_frame_seq_chk.sv]
`timescale 1ns/1ns
// ************************************************************
// sequencer output checker
// ************************************************************
module cfs_frame_seq_chk (
  input logic                          CLOCK_I,
  input logic                          RST_N_I,
  input logic                          VERTICAL_PHASE_A_O,
  input logic                          VERTICAL_PHASE_B_O,
  input logic                          VERTICAL_THIRD_LEVEL_O,
  input logic                          EXPOSURE_LEVEL_O,
  input logic                          HCLK_GATE_O,
  input logic [cfs_pkg::FE_BIN_W-1:0]  HBIN_FACTOR_O,
  input logic [cfs_pkg::CNT_W-1:0]     LINE_COUNT_O,
  input logic                          ACTIVE_FRAME_TABLE_O
);
  logic [12:0] a_run_q;

  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  // length of the current phase A pulse
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      a_run_q <= 13'h0;
    end else begin
      a_run_q <= VERTICAL_PHASE_A_O ? a_run_q + 13'h1 : 13'h0;
    end
  end

  a_exp_idle: assert property (EXPOSURE_LEVEL_O |-> !VERTICAL_PHASE_A_O &&
    !VERTICAL_PHASE_B_O && !VERTICAL_THIRD_LEVEL_O && !HCLK_GATE_O)
    else $error("vertical or horizontal clock active in integration");
  a_third_on_b: assert property (VERTICAL_THIRD_LEVEL_O |->
    VERTICAL_PHASE_B_O && !HCLK_GATE_O)
    else $error("third level without phase B");
  a_hclk_quiet: assert property (HCLK_GATE_O |-> !VERTICAL_PHASE_A_O &&
    !VERTICAL_PHASE_B_O) else $error("vertical clock during readout");
  a_a_width: assert property ($fell(VERTICAL_PHASE_A_O) |->
    a_run_q == 13'h0026 || a_run_q == 13'h0166)
    else $error("phase A pulse width wrong");
  a_b_lead: assert property ($rose(VERTICAL_PHASE_A_O) |->
    VERTICAL_PHASE_B_O && $past(VERTICAL_PHASE_B_O))
    else $error("phase A rose without phase B overlap");
  a_b_trail: assert property ($fell(VERTICAL_PHASE_A_O) |->
    VERTICAL_PHASE_B_O) else $error("phase B fell before phase A");
  a_v_first: assert property ($rose(HCLK_GATE_O) |->
    $past(VERTICAL_PHASE_B_O)) else $error("readout not after transfer");
  a_hbin_sel: assert property ($rose(HCLK_GATE_O) |-> HBIN_FACTOR_O ==
    (ACTIVE_FRAME_TABLE_O ? 2'h1 : 2'h0)) else $error("binning factor wrong");
  a_line_step: assert property ($changed(LINE_COUNT_O) |->
    LINE_COUNT_O == $past(LINE_COUNT_O) + 13'h1 || LINE_COUNT_O == 13'h0)
    else $error("line counter jumped");

  c_table_one: cover property ($rose(ACTIVE_FRAME_TABLE_O));
  c_integ_end: cover property ($fell(EXPOSURE_LEVEL_O));
  c_bin_line: cover property ($rose(HCLK_GATE_O) && ACTIVE_FRAME_TABLE_O);
endmodule

bind cfs_frame_seq cfs_frame_seq_chk u_chk (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
  .VERTICAL_PHASE_A_O(VERTICAL_PHASE_A_O),
  .VERTICAL_PHASE_B_O(VERTICAL_PHASE_B_O),
  .VERTICAL_THIRD_LEVEL_O(VERTICAL_THIRD_LEVEL_O),
  .EXPOSURE_LEVEL_O(EXPOSURE_LEVEL_O), .HCLK_GATE_O(HCLK_GATE_O),
  .HBIN_FACTOR_O(HBIN_FACTOR_O), .LINE_COUNT_O(LINE_COUNT_O),
  .ACTIVE_FRAME_TABLE_O(ACTIVE_FRAME_TABLE_O));

// [verif/cfs_sensor_model.sv]
`timescale 1ns/1ns
// ************************************************************
// sensor clock driver observer
// ************************************************************
module cfs_sensor_model (
  input  logic        clk_i,
  input  logic        rst_n_i,
  input  logic        ph_a_i,
  input  logic        ph_b_i,
  input  logic        third_i,
  input  logic        hclk_i,
  output logic [15:0] a_pulses_o,
  output logic [15:0] h_pulses_o,
  output logic [15:0] a_len_o,
  output logic [15:0] t_len_o,
  output logic [15:0] b_max_o
);
  logic [15:0] a_run_q;
  logic [15:0] b_run_q;
  logic [15:0] t_run_q;
  logic [3:0]  lvl_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {a_run_q, b_run_q, t_run_q, lvl_q} <= '0;
      {a_pulses_o, h_pulses_o, a_len_o, t_len_o, b_max_o} <= '0;
    end else begin
      lvl_q <= {ph_a_i, ph_b_i, third_i, hclk_i};
      a_run_q <= ph_a_i ? a_run_q + 16'h1 : 16'h0;
      b_run_q <= ph_b_i ? b_run_q + 16'h1 : 16'h0;
      t_run_q <= third_i ? t_run_q + 16'h1 : 16'h0;
      if (lvl_q[3] && !ph_a_i) a_len_o <= a_run_q;
      if (lvl_q[1] && !third_i) t_len_o <= t_run_q;
      if (lvl_q[2] && !ph_b_i && b_run_q > b_max_o) b_max_o <= b_run_q;
      if (ph_a_i && !lvl_q[3]) a_pulses_o <= a_pulses_o + 16'h1;
      if (hclk_i && !lvl_q[0]) h_pulses_o <= h_pulses_o + 16'h1;
      // a new frame starts at third-level rise
      if (third_i && !lvl_q[1]) begin
        {a_pulses_o, h_pulses_o, b_max_o} <= '0;
      end
    end
  end
endmodule

// [verif/cfs_frame_seq_tb_top.sv]
`timescale 1ns/1ns
// ************************************************************
// sequencer testbench
// ************************************************************
module cfs_frame_seq_tb_top;
  typedef struct packed {
    logic        ptr;
    logic [15:0] lines;
    logic [15:0] apul;
    logic        act;
  } cfs_row_type;

  logic CLOCK_I, RST_N_I, SER_CLK_I, SER_DATA_I, SER_LOAD_N_I;
  logic FRAME_END_PULSE_I, ph_a, ph_b, third, expo, hclk, act;
  logic aux, drain, shut;
  logic [10:0] oen;
  logic [15:0] n_shut = 16'h0;
  logic [1:0]  hbin;
  logic [12:0] lc;
  logic [15:0] m_apul, m_hpul, m_alen, m_tlen, m_bmax;
  int          n_mismatch;
  int          samples_checked;
  int          cyc;
  cfs_row_type rows [2] = '{'{1'b1, 16'h0003, 16'h0004, 1'b1},
                            '{1'b1, 16'h0210, 16'h0421, 1'b1}};

  cfs_frame_seq DUT (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
    .SER_CLK_I(SER_CLK_I), .SER_DATA_I(SER_DATA_I),
    .SER_LOAD_N_I(SER_LOAD_N_I), .FRAME_END_PULSE_I(FRAME_END_PULSE_I),
    .VERTICAL_PHASE_A_O(ph_a), .VERTICAL_PHASE_B_O(ph_b),
    .VERTICAL_THIRD_LEVEL_O(third), .VERTICAL_AUX_O(aux),
    .EXPOSURE_LEVEL_O(expo), .DRAIN_GATE_CTRL_O(drain), .HCLK_GATE_O(hclk),
    .OUTPUT_ENABLES_O(oen), .HBIN_FACTOR_O(hbin),
    .FORCE_SHUTTER_START_O(shut), .LINE_COUNT_O(lc),
    .ACTIVE_FRAME_TABLE_O(act));

  cfs_sensor_model u_sensor (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .ph_a_i(ph_a), .ph_b_i(ph_b), .third_i(third), .hclk_i(hclk),
    .a_pulses_o(m_apul), .h_pulses_o(m_hpul), .a_len_o(m_alen),
    .t_len_o(m_tlen), .b_max_o(m_bmax));

  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // header: select 011 msb first, write, address lsb first
  task automatic ser_write(input logic [3:0] a, input logic [39:0] d);
    logic [47:0] s;
    s = {d, a, 4'h6};
    @(posedge CLOCK_I) SER_LOAD_N_I <= 1'b0;
    for (int i = 0; i < 48; i++) begin
      SER_DATA_I <= s[i];
      repeat (4) @(posedge CLOCK_I);
      SER_CLK_I <= 1'b1;
      repeat (4) @(posedge CLOCK_I);
      SER_CLK_I <= 1'b0;
    end
    repeat (4) @(posedge CLOCK_I);
    SER_LOAD_N_I <= 1'b1;
    repeat (8) @(posedge CLOCK_I);
  endtask

  task automatic wait_exp(input logic v, input int lim);
    int k;
    k = 0;
    while (expo !== v && k < lim) begin
      @(negedge CLOCK_I);
      k++;
    end
    chk({15'h0, expo}, {15'h0, v});
  endtask

  initial begin
    CLOCK_I = 1'b0;
    forever #5 CLOCK_I = ~CLOCK_I;
  end

  // hang guard, sized for the full binned frame
  always @(posedge CLOCK_I) begin
    cyc <= cyc + 1;
    if (shut) n_shut <= n_shut + 16'h1;
    if (cyc == 95000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    {RST_N_I, SER_CLK_I, SER_DATA_I, FRAME_END_PULSE_I} = 4'h0;
    SER_LOAD_N_I = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    wait_exp(1'b1, 10);
    chk({3'h0, lc}, 16'h0000);
    repeat (50) @(negedge CLOCK_I);
    chk({15'h0, expo}, 16'h0001);
    // shorten the normal frame to three lines
    ser_write(4'h8, {2'h2, 4'h0, 4'h2, 13'h0003, 1'b0, 16'he2c5});
    for (int i = 0; i < 2; i++) begin
      ser_write(4'h0, {39'h0, rows[i].ptr});
      @(posedge CLOCK_I) FRAME_END_PULSE_I <= 1'b1;
      repeat (4) @(posedge CLOCK_I);
      FRAME_END_PULSE_I <= 1'b0;
      wait_exp(1'b0, 20);
      wait_exp(1'b1, 85000);
      repeat (3) @(negedge CLOCK_I);
      chk(m_hpul, rows[i].lines);
      chk(m_apul, rows[i].apul);
      chk(m_alen, 16'h0026);
      chk(m_tlen, 16'h0168);
      chk(m_bmax, 16'h05b4);
      chk({15'h0, act}, {15'h0, rows[i].act});
    end
    ser_write(4'h9, 40'h00100c8001);
    @(negedge CLOCK_I);
    chk({14'h0, aux, drain}, 16'h0003);
    @(posedge CLOCK_I) FRAME_END_PULSE_I <= 1'b1;
    repeat (3000) @(posedge CLOCK_I) FRAME_END_PULSE_I <= 1'b0;
    @(negedge CLOCK_I);
    chk({5'h0, oen}, 16'h0716);
    chk({14'h0, hbin}, 16'h0001);
    @(posedge CLOCK_I) RST_N_I <= 1'b0;
    repeat (2) @(negedge CLOCK_I);
    chk({15'h0, act}, 16'h0000);
    chk({3'h0, lc}, 16'h0000);
    @(posedge CLOCK_I) RST_N_I <= 1'b1;
    wait_exp(1'b1, 10);
    chk({15'h0, act}, 16'h0000);
    chk({14'h0, aux, drain}, 16'h0000);
    chk(n_shut, 16'h0001);
    print_verdict();
  end
endmodule
